// file: design/cjm_exec.sv
// Functional notes
// - accum_branch decodes 3-bit designator into eight tests; address used unindexed.
// - all-ones negative zero and positive zero both count as zero.
// - accum_branch designators 0-3 jump on zero, nonzero, positive, negative.
// - accum_branch designators 4-7 return-jump on the same four conditions.
// - aux_branch uses same eight encodings on the auxiliary register, unindexed.
// - integer_product puts 96-bit product, high half in aux, low in accumulator.
// - integer divide of aux:acc by storage; quotient to acc, remainder signed like dividend.
// - divide overflow sets a sticky indicator; interrupt raised when selected.
// - fraction_product forms fractional 96-bit product in acc:aux, multiplier discarded.
// - fraction_quotient divides acc:aux; quotient acc, remainder signed like dividend in aux.
// - float_sum/float_difference normalize and round into acc, residue into aux.
// - float_product/float_ratio normalize and round into acc, residue into aux.
// - float exponent overflow or underflow sets range indicator; interrupt when selected.
// - normalize_accum rotates acc left, k minus one per shift, until bits differ or k zero.
// - normalize_double rotates acc:aux left as one unit with the same stop test.
// - after any scale end, remaining count written to designated index register.
// - scale count accepts 0 to 777777 octal; shift fault indicator untouched.
// - storage_sign_test gives full exit on negative word, half exit on positive.
// - storage_sign_test modifies no operational register.
// - in the double register the accumulator is the upper 48 bits, except for integer product and divide, where aux is upper.
`timescale 1ns/1ps
`default_nettype none
module cjm_exec #(
    parameter int K_WIDTH = 18
) (
    input  wire logic                clk,            // 100 MHz clock
    input  wire logic                nrst,           // async reset, active low
    input  wire logic                start,          // begin one instruction
    input  wire logic [5:0]          opcode,         // function code
    input  wire logic [2:0]          desig,          // condition or index designator
    input  wire logic [14:0]         base_addr,      // base execution address, unindexed
    input  wire logic [K_WIDTH-1:0]  shift_k,        // scale count
    input  wire logic [14:0]         ret_addr,       // program address saved by return jump
    input  wire logic [47:0]         operand,        // storage word at execution address
    input  wire logic [47:0]         acc_in,         // accumulator before the instruction
    input  wire logic [47:0]         aux_in,         // auxiliary register before the instruction
    input  wire logic                div_int_sel,    // divide overflow interrupt selected
    input  wire logic                range_int_sel,  // range fault interrupt selected
    input  wire logic                div_clear,      // sense-and-clear of divide indicator
    input  wire logic                range_clear,    // sense-and-clear of range indicator
    output logic                     busy,           // instruction in progress
    output logic                     done,           // one-cycle completion pulse
    output logic [47:0]              acc,            // accumulator result
    output logic [47:0]              aux,            // auxiliary register result
    output logic                     regs_we,        // acc and aux results valid to write back
    output logic                     jump,           // branch taken
    output logic [14:0]              jump_addr,      // next instruction address when taken
    output logic                     ret_write,      // store ret_word at base_addr
    output logic [14:0]              ret_word,       // return address to store
    output logic                     full_exit,      // advance to next program step
    output logic                     half_exit,      // go to lower instruction
    output logic                     index_we,       // write index register
    output logic [2:0]               index_sel,      // index register number
    output logic [K_WIDTH-1:0]       index_val,      // reduced scale count
    output logic                     bad_op,         // opcode not handled here
    output logic                     div_overflow,   // sticky divide overflow indicator
    output logic                     range_fault,    // sticky float range indicator
    output logic                     div_irq,        // divide overflow interrupt
    output logic                     range_irq       // range fault interrupt
);

    generate
        if (K_WIDTH < cjm_pkg::KW) begin : g_chk
            $error("cjm_exec: K_WIDTH must hold 777777 octal");
        end
    endgenerate

    function automatic logic is_zero(input logic [47:0] v);
        is_zero = (&v) | ~(|v);
    endfunction

    function automatic logic [6:0] lead_zeros(input logic [73:0] v);
        lead_zeros = cjm_pkg::EXT_BITS;
        for (int i = 0; i < cjm_pkg::EXT_W; i++) begin
            if (v[i]) begin
                lead_zeros = 7'(cjm_pkg::EXT_W - 1 - i);
            end
        end
    endfunction

    cjm_pkg::cjm_state_e state;
    logic [K_WIDTH-1:0]  kcnt;
    logic                dbl;

    // ---- decode
    wire is_acc_br  = opcode == cjm_pkg::OP_ACC_BR;
    wire is_aux_br  = opcode == cjm_pkg::OP_AUX_BR;
    wire is_br      = is_acc_br | is_aux_br;

    wire is_imul    = opcode == cjm_pkg::OP_INT_MUL;
    wire is_idiv    = opcode == cjm_pkg::OP_INT_DIV;
    wire is_fmul    = opcode == cjm_pkg::OP_FRAC_MUL;
    wire is_fdiv    = opcode == cjm_pkg::OP_FRAC_DIV;

    wire is_fl_add  = opcode == cjm_pkg::OP_FL_SUM || opcode == cjm_pkg::OP_FL_DIFF;
    wire is_fl_mul  = opcode == cjm_pkg::OP_FL_PROD;
    wire is_fl_div  = opcode == cjm_pkg::OP_FL_RATIO;
    wire is_float   = is_fl_add | is_fl_mul | is_fl_div;

    wire is_scale   = opcode == cjm_pkg::OP_NORM_ACC || opcode == cjm_pkg::OP_NORM_DBL;
    wire is_skip    = opcode == cjm_pkg::OP_SIGN_TST;
    wire is_arith   = is_imul | is_idiv | is_fmul | is_fdiv | is_float;

    wire accept     = start && state == cjm_pkg::ST_IDLE;

    // ---- branch tests; base address is never index-modified
    wire [47:0] br_reg  = is_aux_br ? aux_in : acc_in;
    wire        br_zero = is_zero(br_reg);
    wire        br_neg  = br_reg[cjm_pkg::SIGN] & ~br_zero;

    logic       br_cond;
    always_comb begin
        case (desig[1:0])
            cjm_pkg::CND_ZERO:    br_cond = br_zero;
            cjm_pkg::CND_NONZERO: br_cond = ~br_zero;
            cjm_pkg::CND_POS:     br_cond = ~br_neg;
            cjm_pkg::CND_NEG:     br_cond = br_neg;
            default:              br_cond = 1'b0;
        endcase
    end
    wire        br_taken = is_br & br_cond;
    wire        br_ret   = desig[cjm_pkg::RET_BIT];
    wire [14:0] br_dest  = br_ret ? base_addr + 15'h0001 : base_addr;

    // ---- ones-complement magnitudes
    wire        sa    = acc_in[cjm_pkg::SIGN];
    wire        sm    = operand[cjm_pkg::SIGN];
    wire [46:0] mag_a = sa ? ~acc_in[46:0] : acc_in[46:0];
    wire [46:0] mag_m = sm ? ~operand[46:0] : operand[46:0];

    // integer and fraction product share one multiplier
    wire [93:0] prod     = mag_a * mag_m;
    wire [95:0] prod_pos = is_fmul ? {1'b0, prod, 1'b0} : {2'h0, prod};
    wire [95:0] prod_sgn = (sa ^ sm) ? ~prod_pos : prod_pos;

    // integer dividend is aux:acc, fraction dividend acc:aux
    wire [95:0] dvd      = is_fdiv ? {acc_in, aux_in} : {aux_in, acc_in};
    wire        dvd_s    = dvd[cjm_pkg::PAIR-1];
    wire [94:0] dvd_mag  = dvd_s ? ~dvd[94:0] : dvd[94:0];

    // fraction quotient has one less binary weight, hence the doubled divisor
    wire [47:0] dvs      = is_fdiv ? {mag_m, 1'b0} : {1'b0, mag_m};
    wire        dvs_zero = ~(|mag_m);
    wire [47:0] dvs_safe = dvs_zero ? 48'h000000000001 : dvs;

    wire [94:0] quo      = dvd_mag / dvs_safe;
    wire [47:0] rem_full = 48'(dvd_mag % dvs_safe);
    wire [46:0] rem_mag  = is_fdiv ? rem_full[47:1] : rem_full[46:0];

    wire        div_ovf  = dvs_zero | (|quo[94:47]);
    wire [47:0] quo_sgn  = (dvd_s ^ sm) ? ~{1'b0, quo[46:0]} : {1'b0, quo[46:0]};
    wire [47:0] rem_sgn  = dvd_s ? ~{1'b0, rem_mag} : {1'b0, rem_mag};

    // ---- floating point, coefficient taken as a fraction below bit 71
    wire [46:0] fa = mag_a;
    wire [46:0] fb = mag_m;
    wire        float_difference = (opcode == cjm_pkg::OP_FL_DIFF) ? ~sm : sm;

    wire [10:0] ea = fa[46:36];
    wire [10:0] eb = fb[46:36];
    wire [35:0] ma = fa[35:0];
    wire [35:0] mb = fb[35:0];

    wire        a_big   = ea >= eb;
    wire [10:0] ediff   = a_big ? ea - eb : eb - ea;

    wire [73:0] big74   = {2'h0, a_big ? ma : mb, 36'h0};
    wire [73:0] sml74   = ediff > 11'(cjm_pkg::EXT_W) ? 74'h0 : {2'h0, a_big ? mb : ma, 36'h0} >> ediff;
    wire        big_s   = a_big ? sa : float_difference;
    wire        sml_s   = a_big ? float_difference : sa;
    wire        same_s  = big_s == sml_s;
    wire        big_ge  = big74 >= sml74;

    wire [73:0] add_r   = same_s ? big74 + sml74 : (big_ge ? big74 - sml74 : sml74 - big74);
    wire        add_s   = same_s | big_ge ? big_s : sml_s;
    wire [10:0] add_e   = a_big ? ea : eb;

    wire [73:0] mul_r   = {2'h0, 72'(ma) * 72'(mb)};
    wire [106:0] div_n  = {ma, 71'h0};
    wire        mb_zero = ~(|mb);
    wire [73:0] div_r   = 74'(div_n / {71'h0, mb_zero ? 36'h000000001 : mb});

    wire signed [13:0] ea_x = signed'({3'h0, ea});
    wire signed [13:0] eb_x = signed'({3'h0, eb});

    logic [73:0]        fr;
    logic               fs;
    logic signed [13:0] fe;

    always_comb begin
        if (is_fl_mul) begin
            fr = mul_r;
            fs = sa ^ sm;
            fe = ea_x + eb_x - cjm_pkg::EXP_BIAS;
        end else if (is_fl_div) begin
            fr = div_r;
            fs = sa ^ sm;
            fe = ea_x - eb_x + cjm_pkg::EXP_BIAS;
        end else begin
            fr = add_r;
            fs = add_s;
            fe = signed'({3'h0, add_e});
        end
    end

    // normalize so the leading one lands just below the two guard bits
    wire [6:0]  lz     = lead_zeros(fr);
    wire        fr_nil = ~(|fr);
    wire [73:0] fn     = (lz >= cjm_pkg::EXT_LEAD) ? fr << (lz - cjm_pkg::EXT_LEAD)
                                                   : fr >> (cjm_pkg::EXT_LEAD - lz);
    wire signed [13:0] fe_n = fe + signed'({7'h0, cjm_pkg::EXT_LEAD}) - signed'({7'h0, lz});

    // round on the first residue bit; a carry out renormalizes by one
    wire [36:0] rnd    = {1'b0, fn[71:36]} + {36'h0, fn[35]};
    wire [35:0] mant_f = rnd[36] ? rnd[36:1] : rnd[35:0];
    wire signed [13:0] fe_f = rnd[36] ? fe_n + 14'sh0001 : fe_n;

    wire        fl_rng = ~fr_nil & ((fe_f < 14'sh0000) | (fe_f > cjm_pkg::EXP_MAX))
                         | (is_fl_div & mb_zero);
    wire [47:0] fl_pos = fr_nil ? 48'h0 : {1'b0, fe_f[10:0], mant_f};
    wire [47:0] fl_acc = fs ? ~fl_pos : fl_pos;
    wire [47:0] fl_aux = {12'h0, fn[35:0]};

    // ---- next register values for one-cycle operations
    logic [47:0] next_acc;
    logic [47:0] next_aux;

    always_comb begin
        next_acc = acc_in;
        next_aux = aux_in;
        if (is_imul) begin
            next_aux = prod_sgn[95:48];
            next_acc = prod_sgn[47:0];
        end else if (is_fmul) begin
            next_acc = prod_sgn[95:48];
            next_aux = prod_sgn[47:0];
        end else if (is_idiv | is_fdiv) begin
            next_acc = quo_sgn;
            next_aux = rem_sgn;
        end else if (is_float) begin
            next_acc = fl_acc;
            next_aux = fl_aux;
        end
    end

    // ---- scale step
    wire        sc_stop = ~(|kcnt) | (acc[cjm_pkg::SIGN] != acc[cjm_pkg::SIGN_NEXT]);
    wire [47:0] rot_acc = {acc[46:0], dbl ? aux[cjm_pkg::SIGN] : acc[cjm_pkg::SIGN]};
    wire [47:0] rot_aux = dbl ? {aux[46:0], acc[cjm_pkg::SIGN]} : aux;

    assign busy    = state != cjm_pkg::ST_IDLE;
    assign div_irq   = div_overflow & div_int_sel;
    assign range_irq = range_fault & range_int_sel;

    wire set_div = accept & (is_idiv | is_fdiv) & div_ovf;
    wire set_rng = accept & is_float & fl_rng;

    // sticky indicators: a set in the clear cycle wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_overflow <= 1'b0;
            range_fault  <= 1'b0;
        end else begin
            div_overflow <= set_div | (div_overflow & ~div_clear);
            range_fault  <= set_rng | (range_fault & ~range_clear);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state     <= cjm_pkg::ST_IDLE;
            kcnt      <= '0;
            dbl       <= 1'b0;
            acc       <= 48'h0;
            aux       <= 48'h0;
            done      <= 1'b0;
            regs_we   <= 1'b0;
            jump      <= 1'b0;
            jump_addr <= 15'h0;
            ret_write <= 1'b0;
            ret_word  <= 15'h0;
            full_exit <= 1'b0;
            half_exit <= 1'b0;
            index_we  <= 1'b0;
            index_sel <= 3'h0;
            index_val <= '0;
            bad_op    <= 1'b0;
        end else begin
            done      <= 1'b0;
            regs_we   <= 1'b0;
            jump      <= 1'b0;
            ret_write <= 1'b0;
            full_exit <= 1'b0;
            half_exit <= 1'b0;
            index_we  <= 1'b0;
            bad_op    <= 1'b0;
            case (state)
                cjm_pkg::ST_IDLE: begin
                    if (accept && is_scale) begin
                        state     <= cjm_pkg::ST_SCALE;
                        dbl       <= opcode == cjm_pkg::OP_NORM_DBL;
                        kcnt      <= shift_k;
                        index_sel <= desig;
                        acc       <= acc_in;
                        aux       <= aux_in;
                    end else if (accept) begin
                        done      <= 1'b1;
                        acc       <= next_acc;
                        aux       <= next_aux;
                        regs_we   <= is_arith;
                        jump      <= br_taken;
                        jump_addr <= br_dest;
                        ret_write <= br_taken & br_ret;
                        ret_word  <= ret_addr;
                        full_exit <= is_skip & operand[cjm_pkg::SIGN];
                        half_exit <= is_skip & ~operand[cjm_pkg::SIGN];
                        bad_op    <= ~(is_br | is_arith | is_skip);
                    end
                end
                cjm_pkg::ST_SCALE: begin
                    if (sc_stop) begin
                        state     <= cjm_pkg::ST_IDLE;
                        done      <= 1'b1;
                        regs_we   <= 1'b1;
                        index_we  <= 1'b1;
                        index_val <= kcnt;
                    end else begin
                        acc  <= rot_acc;
                        aux  <= rot_aux;
                        kcnt <= kcnt - 1'b1;
                    end
                end
                default: state <= cjm_pkg::ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: design/cjm_pkg.sv
package cjm_pkg;
    localparam int WORD       = 48;
    localparam int PAIR       = 96;
    localparam int ADDR       = 15;
    localparam int KW         = 18;
    localparam int SIGN       = 47;
    localparam int SIGN_NEXT  = 46;
    // opcodes of the instructions handled here
    localparam logic [5:0] OP_ACC_BR   = 6'h12;
    localparam logic [5:0] OP_AUX_BR   = 6'h13;
    localparam logic [5:0] OP_INT_MUL  = 6'h14;
    localparam logic [5:0] OP_INT_DIV  = 6'h15;
    localparam logic [5:0] OP_FRAC_MUL = 6'h16;
    localparam logic [5:0] OP_FRAC_DIV = 6'h17;
    localparam logic [5:0] OP_FL_SUM   = 6'h18;
    localparam logic [5:0] OP_FL_DIFF  = 6'h19;
    localparam logic [5:0] OP_FL_PROD  = 6'h1A;
    localparam logic [5:0] OP_FL_RATIO = 6'h1B;
    localparam logic [5:0] OP_NORM_ACC = 6'h1C;
    localparam logic [5:0] OP_NORM_DBL = 6'h1D;
    localparam logic [5:0] OP_SIGN_TST = 6'h1E;
    // branch conditions, low two designator bits
    localparam logic [1:0] CND_ZERO    = 2'h0;
    localparam logic [1:0] CND_NONZERO = 2'h1;
    localparam logic [1:0] CND_POS     = 2'h2;
    localparam logic [1:0] CND_NEG     = 2'h3;
    localparam int RET_BIT             = 2;
    // packed float: sign, biased exponent, coefficient
    localparam int EXP_W      = 11;
    localparam int MANT_W     = 36;
    localparam int EXT_W      = 74;
    localparam int XE_W       = 14;
    localparam logic signed [13:0] EXP_BIAS = 14'sh0400;
    localparam logic signed [13:0] EXP_MAX  = 14'sh07FF;
    localparam logic [6:0] EXT_LEAD   = 7'h02;
    localparam logic [6:0] EXT_BITS   = 7'h4A;
    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SCALE = 1'b1
    } cjm_state_e;
endpackage

// file: tb/cjm_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cjm_exec_chk #(
    parameter int K_WIDTH = 18
) (
    input wire logic               clk,          // clock
    input wire logic               nrst,         // reset
    input wire logic               start,        // request
    input wire logic [5:0]         opcode,       // op
    input wire logic [2:0]         desig,        // designator
    input wire logic [14:0]        base_addr,    // m
    input wire logic [K_WIDTH-1:0] shift_k,      // k
    input wire logic [47:0]        operand,      // storage word
    input wire logic [47:0]        acc_in,       // A before
    input wire logic               busy,         // running
    input wire logic               done,         // end pulse
    input wire logic [47:0]        acc,          // A after
    input wire logic [47:0]        aux,          // Q after
    input wire logic               regs_we,      // write back
    input wire logic               jump,         // taken
    input wire logic [14:0]        jump_addr,    // target
    input wire logic               ret_write,    // save return
    input wire logic               full_exit,    // exit
    input wire logic               half_exit,    // half exit
    input wire logic               index_we,     // index write
    input wire logic [K_WIDTH-1:0] index_val,    // reduced k
    input wire logic               div_overflow, // indicator
    input wire logic               div_clear     // clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic  tk = start && !busy;
    wire logic  az = (acc_in == 48'h0) || (acc_in == '1);
    logic [47:0] acc_t;
    logic [47:0] op_t;
    // operands as taken at the accept edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_t <= '0;
            op_t  <= '0;
        end else if (tk) begin
            acc_t <= acc_in;
            op_t  <= operand;
        end
    end
    property p_br;
        tk && opcode == cjm_pkg::OP_ACC_BR |=> done && !regs_we;
    endproperty
    a_br: assert property (p_br) else $error("branch result wrong");
    property p_zero;
        tk && opcode == cjm_pkg::OP_ACC_BR && desig == 3'h0 && az |=> jump && jump_addr == $past(base_addr);
    endproperty
    a_zero: assert property (p_zero) else $error("zero jump missed");
    property p_ret;
        tk && opcode == cjm_pkg::OP_ACC_BR && desig == 3'h4 && az |=> ret_write && jump_addr == $past(base_addr) + 15'h1;
    endproperty
    a_ret: assert property (p_ret) else $error("return jump wrong");
    property p_mul;
        tk && opcode == cjm_pkg::OP_INT_MUL && !acc_in[47] && !operand[47] |=> regs_we && {aux, acc} == acc_t * op_t;
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");
    property p_skip;
        tk && opcode == cjm_pkg::OP_SIGN_TST |=> full_exit == op_t[47] && half_exit == !op_t[47] && !regs_we;
    endproperty
    a_skip: assert property (p_skip) else $error("skip exit wrong");
    property p_k0;
        tk && opcode == cjm_pkg::OP_NORM_ACC && shift_k == '0 |=> busy ##1 done && index_we && index_val == '0 && acc == acc_t;
    endproperty
    a_k0: assert property (p_k0) else $error("zero count scale wrong");
    property p_k1;
        tk && opcode == cjm_pkg::OP_NORM_ACC && shift_k == 1 && acc_in[47] == acc_in[46]
            |=> busy[*2] ##1 done && index_val == '0 && acc == {acc_t[46:0], acc_t[47]};
    endproperty
    a_k1: assert property (p_k1) else $error("single shift scale wrong");
    property p_div0;
        tk && opcode == cjm_pkg::OP_INT_DIV && operand == '0 |=> done && div_overflow;
    endproperty
    a_div0: assert property (p_div0) else $error("divide overflow not set");
    property p_sticky;
        div_overflow && !div_clear |=> div_overflow;
    endproperty
    a_sticky: assert property (p_sticky) else $error("indicator dropped");
    c_dbl: cover property (tk && opcode == cjm_pkg::OP_NORM_DBL);
    c_ret: cover property (jump && ret_write);
    c_ovf: cover property (div_overflow);
endmodule
bind cjm_exec cjm_exec_chk #(.K_WIDTH(K_WIDTH)) u_chk (.clk, .nrst, .start, .opcode, .desig, .base_addr,
    .shift_k, .operand, .acc_in, .busy, .done, .acc, .aux, .regs_we, .jump, .jump_addr, .ret_write,
    .full_exit, .half_exit, .index_we, .index_val, .div_overflow, .div_clear);
`default_nettype wire

// file: tb/cjm_core_store.sv
`timescale 1ns/1ps
`default_nettype none
module cjm_core_store (
    input  wire logic        clk,       // processor clock
    input  wire logic [14:0] addr,      // execution address
    input  wire logic        ret_write, // return address store
    input  wire logic [14:0] ret_word,  // return address
    output logic      [47:0] word       // word at addr
);
    logic [47:0] mem [16];
    logic [14:0] addr_q;
    // small core, aliased on the low four address bits
    assign word = mem[addr[3:0]];
    always @(posedge clk) begin
        addr_q <= addr;
        if (ret_write) begin
            mem[addr_q[3:0]][14:0] <= ret_word;
        end
    end
endmodule
`default_nettype wire

// file: tb/test_cond_jump_muldiv_float_scale.sv
`timescale 1ns/1ps
`default_nettype none
module test_cond_jump_muldiv_float_scale;
    localparam int KW = 18;
    logic          clk = 1'b0, nrst = 1'b0, start = 1'b0, div_int_sel = 1'b1, div_clear = 1'b0;
    logic [5:0]    opcode = '0;
    logic [2:0]    desig = '0, index_sel;
    logic [14:0]   base_addr = '0, ret_addr = '0, jump_addr, ret_word;
    logic [KW-1:0] shift_k = '0, index_val;
    logic [47:0]   acc_in = '0, aux_in = '0, operand, acc, aux;
    logic          busy, done, regs_we, jump, ret_write, full_exit, half_exit, index_we, bad_op;
    logic          div_overflow, range_fault, div_irq, range_irq;
    int            miscompares = 0, total_checks = 0, cycles = 0;
    cjm_exec #(.K_WIDTH(KW)) u_dut (.clk, .nrst, .start, .opcode, .desig, .base_addr, .shift_k, .ret_addr,
        .operand, .acc_in, .aux_in, .div_int_sel, .range_int_sel(1'b1), .div_clear, .range_clear(1'b0),
        .busy, .done, .acc, .aux, .regs_we, .jump, .jump_addr, .ret_write, .ret_word, .full_exit,
        .half_exit, .index_we, .index_sel, .index_val, .bad_op, .div_overflow, .range_fault, .div_irq,
        .range_irq);
    cjm_core_store u_mem (.clk, .addr(base_addr), .ret_write, .ret_word, .word(operand));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic run(input logic [5:0] op, input logic [2:0] d, input logic [14:0] m, input logic [KW-1:0] k,
                       input logic [47:0] a, input logic [47:0] q);
        int n;
        {opcode, desig, base_addr, shift_k, acc_in, aux_in, ret_addr} = {op, d, m, k, a, q, 15'h2A5A};
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n < 300, 1'b1, "done");
    endtask
    task automatic t_branch();
        logic [47:0] v [4] = '{48'h0, '1, 48'h5, 48'hFFFF_FFFF_FFF0};
        logic        z, ng, hit;
        for (int op = 0; op < 2; op++) begin
            for (int i = 0; i < 4; i++) begin
                for (int d = 0; d < 8; d++) begin
                    z = (v[i] == 48'h0) || (v[i] == '1);
                    ng = v[i][47] && !z;
                    hit = (d % 4 == 0) ? z : (d % 4 == 1) ? !z : (d % 4 == 2) ? !ng : ng;
                    if (op == 0) begin
                        run(cjm_pkg::OP_ACC_BR, d[2:0], 15'h7FF3, '0, v[i], 48'h0);
                    end else begin
                        run(cjm_pkg::OP_AUX_BR, d[2:0], 15'h7FF3, '0, 48'h0, v[i]);
                    end
                    chk(jump, hit, "jump");
                    chk(ret_write, hit && d[2], "ret");
                    if (hit) chk(jump_addr, 15'h7FF3 + d[2], "target");
                end
            end
        end
        chk(u_mem.mem[3][14:0], 15'h2A5A, "saved");
        $display("test branch ended");
    endtask
    task automatic t_muldiv();
        u_mem.mem[1] = 48'h4;
        run(cjm_pkg::OP_INT_MUL, 3'h0, 15'h1, '0, 48'h4000_0000_0003, 48'h0);
        chk({aux, acc}, 96'h1_0000_0000_000C, "mul");
        run(cjm_pkg::OP_INT_MUL, 3'h0, 15'h1, '0, ~48'h3, 48'h0);
        chk({aux, acc}, ~96'hC, "mul neg");
        u_mem.mem[2] = 48'h4000_0000_0000;
        run(cjm_pkg::OP_FRAC_MUL, 3'h0, 15'h2, '0, 48'h4000_0000_0000, 48'h0);
        chk({acc, aux}, {48'h2000_0000_0000, 48'h0}, "fmul");
        run(cjm_pkg::OP_FRAC_DIV, 3'h0, 15'h2, '0, 48'h2000_0000_0000, 48'h0);
        chk({acc, aux}, {48'h4000_0000_0000, 48'h0}, "fdiv");
        u_mem.mem[4] = 48'h5;
        run(cjm_pkg::OP_INT_DIV, 3'h0, 15'h4, '0, 48'h11, 48'h0);
        chk({aux, acc}, {48'h2, 48'h3}, "div");
        run(cjm_pkg::OP_INT_DIV, 3'h0, 15'h4, '0, ~48'h11, '1);
        chk({aux, acc}, {~48'h2, ~48'h3}, "div neg");
        chk(div_overflow, 1'b0, "no ovf");
        run(cjm_pkg::OP_INT_DIV, 3'h0, 15'h0, '0, 48'h11, 48'h0);
        chk({div_overflow, div_irq}, 2'h3, "ovf");
        div_int_sel = 1'b0;
        div_clear = 1'b1;
        #1 chk(div_irq, 1'b0, "masked");
        @(posedge clk);
        #1 div_clear = 1'b0;
        chk(div_overflow, 1'b0, "cleared");
        run(cjm_pkg::OP_FL_DIFF, 3'h0, 15'h2, '0, 48'h4004_0000_0000, 48'h0);
        chk({acc, aux}, {48'h3FF8_0000_0000, 48'h0}, "fdif");
        run(cjm_pkg::OP_FL_RATIO, 3'h0, 15'h0, '0, 48'h0, 48'h0);
        chk({range_fault, range_irq}, 2'h3, "rng");
        $display("test muldiv ended");
    endtask
    task automatic t_scale();
        run(cjm_pkg::OP_NORM_ACC, 3'h5, 15'h0, 18'h3FFFF, 48'h1, 48'h0);
        chk({acc, index_we, index_sel, index_val}, {48'h4000_0000_0000, 1'b1, 3'h5, 18'h3FFD1}, "sca");
        run(cjm_pkg::OP_NORM_ACC, 3'h2, 15'h0, 18'h1, 48'h1, 48'h0);
        chk({acc, index_val}, {48'h2, 18'h0}, "sca k1");
        run(cjm_pkg::OP_NORM_ACC, 3'h0, 15'h0, 18'h0, 48'h1, 48'h0);
        chk({acc, index_we, index_val}, {48'h1, 1'b1, 18'h0}, "sca k0");
        run(cjm_pkg::OP_NORM_DBL, 3'h3, 15'h0, 18'hC8, 48'h0, 48'h1);
        chk({acc, aux, index_val}, {48'h4000_0000_0000, 48'h0, 18'h6A}, "scq");
        $display("test scale ended");
    endtask
    task automatic t_skip();
        u_mem.mem[6] = 48'h8000_0000_0000;
        u_mem.mem[7] = 48'h1;
        run(cjm_pkg::OP_SIGN_TST, 3'h0, 15'h6, '0, 48'h7, 48'h9);
        chk({full_exit, half_exit, regs_we}, 3'h4, "neg");
        run(cjm_pkg::OP_SIGN_TST, 3'h0, 15'h7, '0, 48'h7, 48'h9);
        chk({full_exit, half_exit, regs_we}, 3'h2, "pos");
        run(6'h00, 3'h0, 15'h7, '0, 48'h7, 48'h9);
        chk({bad_op, regs_we, jump}, 3'h4, "bad op");
        $display("test skip ended");
    endtask
    initial begin
        for (int i = 0; i < 16; i++) u_mem.mem[i] = '0;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        t_branch();
        t_muldiv();
        t_scale();
        t_skip();
        end_sim();
    end
endmodule
`default_nettype wire
